// File: verilog/drs_reclaim_scrub.sv
// Purpose: Reclaim remap of logical addresses plus DRAM init and scrub engine
// Assumes: Memory port accepts a command when mem_cmd_ready is high
// Notes:   Normal traffic owns the memory; scrubbing waits for idle cycles
//
// What this block does
// R1 - Check every logical address against remap window
// R2 - Window edges come from base and limit
// R3 - Remapped addresses start at low memory top
// R4 - Reclaim low memory top up to 4G or rows
// R5 - Scrub walks memory reading then writing back
// R6 - Correctable errors fixed, new checks written back
// R7 - Write back always follows a scrub read
// R8 - Scrub changes no stored data bytes of a clean line
// R9 - Scrub address starts at zero after reset
// R10 - One line per interval, advance 64 bytes
// R11 - Write valid ECC to every line after reset
// R12 - ECC corrects any number of bad bits within one byte
// R13 - Interval parameter, yield to traffic, wrap address
// R14 - Addresses outside window pass unmodified
`timescale 1ns/100ps
module drs_reclaim_scrub #(
  parameter int unsigned SCRUB_INTERVAL = drs_pkg::SCRUB_GAP_CYC  // Cycles between line scrubs
) (
  input  wire logic                          sys_clk,            // Core clock
  input  wire logic                          reset_n,            // Async reset, active low
  input  wire logic                          req_valid,          // Logical address offered
  input  wire logic [drs_pkg::ADDR_W-1:0]    req_addr,           // Logical address
  input  wire logic [drs_pkg::ADDR_W-1:0]    remap_window_base,  // Window bottom, inclusive
  input  wire logic [drs_pkg::ADDR_W-1:0]    remap_window_limit, // Window top, inclusive
  input  wire logic [drs_pkg::ADDR_W-1:0]    low_memory_top,     // Top of low memory
  input  wire logic [drs_pkg::ADDR_W-1:0]    last_row_boundary,  // Top of installed memory
  output logic                               phys_valid,         // Translation ready
  output logic      [drs_pkg::ADDR_W-1:0]    phys_addr,          // Physical or passed address
  output logic                               remapped,           // Address was redirected
  output logic                               mem_cmd_valid,      // Scrub command pending
  output logic                               mem_cmd_write,      // Command is a write
  output logic      [drs_pkg::ADDR_W-1:0]    mem_cmd_addr,       // Line address
  output logic      [drs_pkg::CODE_W-1:0]    mem_wdata,          // Codeword to write
  input  wire logic                          mem_cmd_ready,      // Memory takes the command
  input  wire logic                          mem_rd_valid,       // Read data returned
  input  wire logic [drs_pkg::CODE_W-1:0]    mem_rd_data,        // Codeword as read
  output logic                               init_busy,          // Auto-init running
  output logic                               scrub_fixed,        // Pulse, error corrected
  output logic                               scrub_fatal         // Pulse, error uncorrectable
);

  localparam int unsigned CNT_W = 32;  // Interval counter width

  // Refuse an interval the counter cannot serve
  if (SCRUB_INTERVAL < 1) begin : g_bad_interval
    $error("SCRUB_INTERVAL must be at least one cycle");
  end

  // Remap state
  logic                        phys_valid_r;   // Translation result valid
  logic                        phys_valid_nxt;
  logic [drs_pkg::ADDR_W-1:0]  phys_addr_r;    // Translated address
  logic [drs_pkg::ADDR_W-1:0]  phys_addr_nxt;
  logic                        remapped_r;     // Window hit flag
  logic                        remapped_nxt;
  logic [drs_pkg::ADDR_W-1:0]  reclaim_top;    // Lower of 4 GB and installed top
  logic [drs_pkg::ADDR_W-1:0]  remap_target;   // Offset address in reclaimed area
  logic                        in_window;      // Address inside window

  // Scrub state
  drs_pkg::drs_state_type      state_r;        // Engine state
  drs_pkg::drs_state_type      state_nxt;
  logic [drs_pkg::ADDR_W-1:0]  scrub_addr_r;   // Current line address
  logic [drs_pkg::ADDR_W-1:0]  scrub_addr_nxt;
  logic [CNT_W-1:0]            gap_cnt_r;      // Cycles left before next scrub
  logic [CNT_W-1:0]            gap_cnt_nxt;
  logic                        cmd_valid_r;    // Memory command strobe
  logic                        cmd_valid_nxt;
  logic                        cmd_write_r;    // Memory command direction
  logic                        cmd_write_nxt;
  logic [drs_pkg::CODE_W-1:0]  wdata_r;        // Write-back codeword
  logic [drs_pkg::CODE_W-1:0]  wdata_nxt;
  logic                        fixed_r;        // Corrected pulse
  logic                        fixed_nxt;
  logic                        fatal_r;        // Uncorrectable pulse
  logic                        fatal_nxt;
  logic                        init_busy_r;    // Auto-init running, registered
  logic                        init_busy_nxt;
  logic [drs_pkg::ADDR_W-1:0]  line_next;      // Following line, wrapped
  logic [drs_pkg::CODE_W-1:0]  fix_code;       // Repaired codeword
  logic                        fix_err;        // Correctable error in read data
  logic                        fix_fatal;      // Uncorrectable error in read data
  logic                        cmd_taken;      // Command accepted this cycle

  // Single-symbol correction on returning read data
  drs_ecc_fix u_ecc (
    .code_in   (mem_rd_data),
    .code_out  (fix_code),
    .err_fixed (fix_err),
    .err_fatal (fix_fatal)
  );

  // Window compare and translation
  always_comb begin
    reclaim_top  = (last_row_boundary < drs_pkg::ADDR_4G) ? last_row_boundary
                                                           : drs_pkg::ADDR_4G;
    remap_target = req_addr - remap_window_base + low_memory_top;  // [R3]
    in_window    = (req_addr >= remap_window_base)
                && (req_addr <= remap_window_limit);                // [R1] [R2]
    phys_valid_nxt = req_valid;
    phys_addr_nxt  = phys_addr_r;
    remapped_nxt   = 1'b0;
    if (req_valid) begin
      // Redirect only into the hidden span below the reclaim top
      if (in_window && remap_target < reclaim_top) begin            // [R4]
        phys_addr_nxt = remap_target;
        remapped_nxt  = 1'b1;
      end else begin
        phys_addr_nxt = req_addr;                                   // [R14]
      end
    end
  end

  // Translation registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phys_valid_r <= 1'b0;
      phys_addr_r  <= drs_pkg::ADDR_RST;
      remapped_r   <= 1'b0;
    end else begin
      phys_valid_r <= phys_valid_nxt;
      phys_addr_r  <= phys_addr_nxt;
      remapped_r   <= remapped_nxt;
    end
  end

  // Scrub and init sequencing
  always_comb begin
    cmd_taken      = cmd_valid_r && mem_cmd_ready;
    line_next      = scrub_addr_r + drs_pkg::LINE_STEP;
    // Wrap once the top of installed memory is reached
    if (line_next >= last_row_boundary) begin                       // [R13]
      line_next = drs_pkg::ADDR_RST;
    end
    state_nxt      = state_r;
    scrub_addr_nxt = scrub_addr_r;
    gap_cnt_nxt    = gap_cnt_r;
    cmd_valid_nxt  = cmd_valid_r;
    cmd_write_nxt  = cmd_write_r;
    wdata_nxt      = wdata_r;
    fixed_nxt      = 1'b0;
    fatal_nxt      = 1'b0;
    unique case (state_r)
      // Fill every line with zero data and matching check bytes
      drs_pkg::ST_INIT: begin
        cmd_valid_nxt = 1'b1;
        cmd_write_nxt = 1'b1;
        wdata_nxt     = drs_pkg::ecc_encode('0);                    // [R11]
        if (cmd_taken) begin
          scrub_addr_nxt = line_next;
          if (line_next == drs_pkg::ADDR_RST) begin
            state_nxt     = drs_pkg::ST_IDLE;
            cmd_valid_nxt = 1'b0;
            gap_cnt_nxt   = CNT_W'(SCRUB_INTERVAL - 1);
          end
        end
      end
      // Count down, then start only when no normal request is offered
      drs_pkg::ST_IDLE: begin
        if (gap_cnt_r != '0) begin
          gap_cnt_nxt = gap_cnt_r - 1'b1;
        end else if (!req_valid) begin                              // [R13]
          state_nxt     = drs_pkg::ST_RD;
          cmd_valid_nxt = 1'b1;
          cmd_write_nxt = 1'b0;                                     // [R5]
        end
      end
      drs_pkg::ST_RD: begin
        if (cmd_taken) begin
          cmd_valid_nxt = 1'b0;
          state_nxt     = drs_pkg::ST_WAIT;
        end
      end
      // Write back in every case, clean or not
      drs_pkg::ST_WAIT: begin
        if (mem_rd_valid) begin
          state_nxt     = drs_pkg::ST_WR;
          cmd_valid_nxt = 1'b1;
          cmd_write_nxt = 1'b1;                                     // [R7]
          wdata_nxt     = fix_code;                                 // [R6] [R8]
          fixed_nxt     = fix_err;
          fatal_nxt     = fix_fatal;
        end
      end
      drs_pkg::ST_WR: begin
        if (cmd_taken) begin
          cmd_valid_nxt  = 1'b0;
          scrub_addr_nxt = line_next;                               // [R10]
          gap_cnt_nxt    = CNT_W'(SCRUB_INTERVAL - 1);
          state_nxt      = drs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt     = drs_pkg::ST_IDLE;
        cmd_valid_nxt = 1'b0;
      end
    endcase
    // Own flop so the busy output is not a state decode
    init_busy_nxt  = (state_nxt == drs_pkg::ST_INIT);              // [R11]
  end

  // Scrub registers; the address restarts at zero on reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r      <= drs_pkg::ST_INIT;
      scrub_addr_r <= drs_pkg::ADDR_RST;                            // [R9]
      gap_cnt_r    <= '0;
      cmd_valid_r  <= 1'b0;
      cmd_write_r  <= 1'b0;
      wdata_r      <= '0;
      fixed_r      <= 1'b0;
      fatal_r      <= 1'b0;
      init_busy_r  <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      scrub_addr_r <= scrub_addr_nxt;
      gap_cnt_r    <= gap_cnt_nxt;
      cmd_valid_r  <= cmd_valid_nxt;
      cmd_write_r  <= cmd_write_nxt;
      wdata_r      <= wdata_nxt;
      fixed_r      <= fixed_nxt;
      fatal_r      <= fatal_nxt;
      init_busy_r  <= init_busy_nxt;
    end
  end

  // Outputs straight from flops
  assign phys_valid    = phys_valid_r;
  assign phys_addr     = phys_addr_r;
  assign remapped      = remapped_r;
  assign mem_cmd_valid = cmd_valid_r;
  assign mem_cmd_write = cmd_write_r;
  assign mem_cmd_addr  = scrub_addr_r;
  assign mem_wdata     = wdata_r;
  assign init_busy     = init_busy_r;
  assign scrub_fixed   = fixed_r;
  assign scrub_fatal   = fatal_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_read_back;
    state_r == drs_pkg::ST_WAIT && mem_rd_valid;
  endsequence

  sequence s_write_issued;
    cmd_valid_r && cmd_write_r && state_r == drs_pkg::ST_WR;
  endsequence

  remap_valid_a: assert property (req_valid |=> phys_valid_r)  // [R1]
    else $error("Translation not produced");
  remap_hit_a: assert property (req_valid && in_window && remap_target < reclaim_top
      |=> remapped_r && phys_addr_r == $past(req_addr) - $past(remap_window_base)
          + $past(low_memory_top))  // [R2] [R3]
    else $error("Window hit translated wrongly");
  remap_cap_a: assert property (remapped_r |-> phys_addr_r < $past(reclaim_top))  // [R4]
    else $error("Remap beyond reclaim top");
  pass_thru_a: assert property (req_valid && !in_window
      |=> !remapped_r && phys_addr_r == $past(req_addr))  // [R14]
    else $error("Outside address altered");
  read_then_write_a: assert property (s_read_back |=> (s_write_issued
      and (mem_cmd_addr == $past(scrub_addr_r))))  // [R5] [R7]
    else $error("Write back missing after read");
  clean_unchanged_a: assert property ((s_read_back and (!fix_err && !fix_fatal))
      |=> mem_wdata == $past(mem_rd_data))  // [R8]
    else $error("Clean line changed by scrub");
  fix_flag_a: assert property ((s_read_back and fix_err) |=> scrub_fixed ##1 !scrub_fixed)  // [R6] [R12]
    else $error("Correction not flagged");
  line_step_a: assert property ((s_write_issued and mem_cmd_ready)
      |=> scrub_addr_r == $past(line_next) && state_r == drs_pkg::ST_IDLE)  // [R10]
    else $error("Scrub address not advanced");
  init_done_a: assert property ($fell(init_busy) |-> scrub_addr_r == drs_pkg::ADDR_RST)  // [R9] [R11]
    else $error("Scrub not starting at zero");
  yield_a: assert property (state_r == drs_pkg::ST_IDLE && req_valid
      |=> state_r != drs_pkg::ST_RD)  // [R13]
    else $error("Scrub did not yield");

endmodule : drs_reclaim_scrub

// File: verilog/drs_pkg.sv
// Purpose: Shared constants and ECC helpers for reclaim remap and scrub
// Assumes: 144-bit codeword of 16 data bytes plus two check bytes
// Notes:   Check bytes are P (byte parity) and Q (weighted sum in GF(256))
package drs_pkg;

  localparam int unsigned ADDR_W        = 36;          // System address width
  localparam int unsigned DATA_BYTES    = 16;          // Data symbols per codeword
  localparam int unsigned DATA_W        = 128;         // Data bits per codeword
  localparam int unsigned CODE_W        = 144;         // Data plus check bits
  localparam int unsigned P_LSB         = 128;         // Parity byte position
  localparam int unsigned Q_LSB         = 136;         // Weighted byte position
  localparam logic [7:0]  GF_POLY_LOW   = 8'h1d;       // Field polynomial, low byte
  localparam logic [ADDR_W-1:0] LINE_STEP = 36'h0_0000_0040;  // One line, 64 bytes
  localparam logic [ADDR_W-1:0] ADDR_4G   = 36'h1_0000_0000;  // 4 GB boundary
  localparam logic [ADDR_W-1:0] ADDR_RST  = 36'h0_0000_0000;  // Scrub start address

  // Nominal spacing so that 16 GB is covered in about one day
  localparam int unsigned CLK_PERIOD_NS = 50;          // 20 MHz core clock
  localparam int unsigned SCRUB_GAP_NS  = 321865;      // Time between line scrubs
  localparam int unsigned SCRUB_GAP_CYC = SCRUB_GAP_NS / CLK_PERIOD_NS;

  // Scrub engine states, one-hot
  typedef enum logic [4:0] {
    ST_INIT = 5'b0_0001,
    ST_IDLE = 5'b0_0010,
    ST_RD   = 5'b0_0100,
    ST_WAIT = 5'b0_1000,
    ST_WR   = 5'b1_0000
  } drs_state_type;

  // Multiply a field element by alpha
  function automatic logic [7:0] gf_mul2(input logic [7:0] x);
    gf_mul2 = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY_LOW : 8'h00);
  endfunction : gf_mul2

  // Multiply a field element by alpha to the power j
  function automatic logic [7:0] gf_mul_pow(input logic [7:0] x, input int unsigned j);
    logic [7:0] acc;
    acc = x;
    for (int unsigned k = 0; k < j; k++) begin
      acc = gf_mul2(acc);
    end
    gf_mul_pow = acc;
  endfunction : gf_mul_pow

  // Build a codeword with fresh check bytes
  function automatic logic [CODE_W-1:0] ecc_encode(input logic [DATA_W-1:0] d);
    logic [7:0] p;
    logic [7:0] q;
    p = 8'h00;
    q = 8'h00;
    for (int unsigned i = 0; i < DATA_BYTES; i++) begin
      p = p ^ d[8*i +: 8];
      q = q ^ gf_mul_pow(d[8*i +: 8], i);
    end
    ecc_encode = {q, p, d};
  endfunction : ecc_encode

endpackage : drs_pkg

// File: verilog/drs_ecc_fix.sv
// Purpose: Correct one faulty byte symbol of a codeword and regenerate checks
// Assumes: Codeword built by drs_pkg::ecc_encode
// Notes:   Purely combinational; any fault within one byte is repaired
`timescale 1ns/100ps
module drs_ecc_fix (
  input  wire logic [drs_pkg::CODE_W-1:0] code_in,    // Codeword as read
  output logic      [drs_pkg::CODE_W-1:0] code_out,   // Corrected, re-encoded word; codeword as read when uncorrectable
  output logic                            err_fixed,  // Correctable error seen
  output logic                            err_fatal   // Beyond correction
);

  logic [7:0]                  syn_p;   // Parity syndrome, the error value
  logic [7:0]                  syn_q;   // Weighted syndrome
  logic [drs_pkg::DATA_W-1:0]  dat;     // Data after repair
  logic                        found;   // Error located in a data byte

  // Syndromes, location search and repair
  always_comb begin
    syn_p = code_in[drs_pkg::P_LSB +: 8];
    syn_q = code_in[drs_pkg::Q_LSB +: 8];
    for (int unsigned i = 0; i < drs_pkg::DATA_BYTES; i++) begin
      syn_p = syn_p ^ code_in[8*i +: 8];
      syn_q = syn_q ^ drs_pkg::gf_mul_pow(code_in[8*i +: 8], i);
    end
    dat   = code_in[drs_pkg::DATA_W-1:0];
    found = 1'b0;
    // Data byte j is bad when syn_q equals syn_p times alpha^j
    for (int unsigned j = 0; j < drs_pkg::DATA_BYTES; j++) begin
      if (syn_p != 8'h00 && drs_pkg::gf_mul_pow(syn_p, j) == syn_q) begin  // [R12]
        dat[8*j +: 8] = code_in[8*j +: 8] ^ syn_p;
        found         = 1'b1;
      end
    end
    // One nonzero syndrome alone means a bad check byte
    err_fixed = found || ((syn_p == 8'h00) != (syn_q == 8'h00));
    err_fatal = (syn_p != 8'h00 || syn_q != 8'h00) && !err_fixed;
    // Uncorrectable lines go back as read so the fault stays visible
    code_out  = err_fatal ? code_in : drs_pkg::ecc_encode(dat);  // [R6]
  end

endmodule : drs_ecc_fix

// File: bench/drs_mem_model.sv
// Purpose: DRAM array model with check bytes behind the scrub port
// Assumes: 16 lines of 64 bytes, one codeword per line
// Notes:   Ready and read latency wander; errors only where asked
`timescale 1ns/100ps
module drs_mem_model (
  input  wire logic                       sys_clk,   // Core clock
  input  wire logic                       reset_n,   // Async reset, active low
  input  wire logic                       cmd_valid, // Command offered
  input  wire logic                       cmd_write, // Write when high
  input  wire logic [drs_pkg::ADDR_W-1:0] cmd_addr,  // Line address
  input  wire logic [drs_pkg::CODE_W-1:0] wdata,     // Codeword written
  input  wire logic [drs_pkg::ADDR_W-1:0] inj_addr,  // Line read back corrupted
  input  wire logic [drs_pkg::CODE_W-1:0] inj_mask,  // Bits flipped on that read
  output logic                            cmd_ready, // Command accepted
  output logic                            rd_valid,  // Read data pulse
  output logic      [drs_pkg::CODE_W-1:0] rd_data    // Codeword returned
);
  logic [drs_pkg::CODE_W-1:0] mem [16];  // Stored codewords
  logic [drs_pkg::ADDR_W-1:0] rd_a;      // Line of pending read
  int                         wait_r;    // Cycles to data, 0 idle

  // Accept, store, answer after a random delay
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
      wait_r    <= 0;
    end else begin
      cmd_ready <= ($urandom_range(3) != 0);
      rd_valid  <= 1'b0;
      // Stale data is not held, so a late sample shows garbage
      rd_data   <= ~rd_data;
      if (cmd_valid && cmd_ready && cmd_write) begin
        mem[cmd_addr[9:6]] <= wdata;
      end else if (cmd_valid && cmd_ready) begin
        rd_a   <= cmd_addr;
        wait_r <= 1 + $urandom_range(3);
      end
      // Data pulse, corrupted only on the chosen line
      if (wait_r == 1) begin
        rd_valid <= 1'b1;
        rd_data  <= mem[rd_a[9:6]] ^ ((rd_a == inj_addr) ? inj_mask : '0);
      end
      if (wait_r > 0) begin
        wait_r <= wait_r - 1;
      end
    end
  end
endmodule : drs_mem_model

// File: bench/tb.sv
// Purpose: Self-checking bench for remap, auto-init and scrub
// Assumes: Short scrub spacing, 16 installed lines
// Notes:   Expected codewords come from a bench encoder of its own
`timescale 1ns/100ps
module tb;
  localparam int unsigned GAP = 12;                       // Short scrub spacing
  localparam logic [35:0] LRB  = 36'h0_0000_0400;         // 16 lines installed
  localparam logic [35:0] TOP  = 36'h0_0000_0200;         // Low memory top
  localparam logic [35:0] BASE = 36'h0_0000_1000;         // Window bottom
  localparam logic [35:0] LIM  = 36'h0_0000_13ff;         // Window top, past the cap
  logic         sys_clk, reset_n, req_valid, phys_valid, remapped, init_busy;
  logic         mem_cmd_valid, mem_cmd_write, mem_cmd_ready, mem_rd_valid;
  logic         scrub_fixed, scrub_fatal, rd_open, quiet, prev_req, prev_rd;
  logic [35:0]  req_addr, phys_addr, mem_cmd_addr, inj_addr, next_a, rd_a;
  logic [143:0] mem_wdata, mem_rd_data, inj_mask;
  logic [143:0] exp_w [16];                                // Expected lines
  int           err_count, samples_checked, cyc, wr_cyc, wr_total, fix_cnt, fat_cnt, seed_v;

  drs_reclaim_scrub #(.SCRUB_INTERVAL(GAP)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_addr(req_addr), .remap_window_base(BASE), .remap_window_limit(LIM),
    .low_memory_top(TOP), .last_row_boundary(LRB), .phys_valid(phys_valid), .phys_addr(phys_addr),
    .remapped(remapped), .mem_cmd_valid(mem_cmd_valid), .mem_cmd_write(mem_cmd_write),
    .mem_cmd_addr(mem_cmd_addr), .mem_wdata(mem_wdata), .mem_cmd_ready(mem_cmd_ready),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .init_busy(init_busy),
    .scrub_fixed(scrub_fixed), .scrub_fatal(scrub_fatal));
  drs_mem_model mem_u (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(mem_cmd_valid),
    .cmd_write(mem_cmd_write), .cmd_addr(mem_cmd_addr), .wdata(mem_wdata), .inj_addr(inj_addr),
    .inj_mask(inj_mask), .cmd_ready(mem_cmd_ready), .rd_valid(mem_rd_valid), .rd_data(mem_rd_data));

  // Clock, 50 ns period
  always #25 sys_clk = ~sys_clk;

  task automatic chk_flag(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: got %b want %b", $time, msg, got, exp);
    end
  endtask : chk_flag

  task automatic chk_val(input logic [143:0] got, input logic [143:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, msg, got, exp);
    end
  endtask : chk_val

  // Horner form of the weighted check byte, independent of the design helpers
  function automatic logic [143:0] enc(input logic [127:0] d);
    logic [7:0] p;
    logic [7:0] q;
    p = 8'h00;
    q = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      q = {q[6:0], 1'b0} ^ (q[7] ? 8'h1d : 8'h00);
      q = q ^ d[8*i +: 8];
      p = p ^ d[8*i +: 8];
    end
    return {q, p, d};
  endfunction : enc

  // Remap decision: hit flag above translated or passed address
  function automatic logic [36:0] remap_exp(input logic [35:0] a);
    logic [35:0] cap;
    logic [35:0] t;
    cap = (LRB < drs_pkg::ADDR_4G) ? LRB : drs_pkg::ADDR_4G;
    t = a - BASE + TOP;
    if (a >= BASE && a <= LIM && t < cap) return {1'b1, t};
    return {1'b0, a};
  endfunction : remap_exp

  // Watch the memory port: order, addresses, spacing, yield
  always @(posedge sys_clk) begin
    cyc++;
    if (!reset_n) begin
      next_a = '0;
      rd_open = 1'b0;
      wr_cyc = cyc;
      quiet = 1'b1;
      prev_rd = 1'b0;
    end else begin
      fix_cnt += (scrub_fixed === 1'b1);
      fat_cnt += (scrub_fatal === 1'b1);
      if (mem_cmd_valid === 1'b1 && mem_cmd_write === 1'b0 && !prev_rd) begin
        chk_flag(prev_req, 1'b0, "read started under traffic");
        chk_flag(cyc - wr_cyc >= GAP && (!quiet || cyc - wr_cyc <= GAP + 3), 1'b1, "spacing");
      end
      prev_rd = mem_cmd_valid && !mem_cmd_write;
      if (req_valid) quiet = 1'b0;
      if (mem_cmd_valid === 1'b1 && mem_cmd_ready === 1'b1) begin
        chk_val(mem_cmd_addr, rd_open ? rd_a : next_a, "line address");
        chk_flag(rd_open | init_busy, mem_cmd_write, "command order");
        if (mem_cmd_write) begin
          next_a = (mem_cmd_addr + drs_pkg::LINE_STEP == LRB) ? '0 : mem_cmd_addr + drs_pkg::LINE_STEP;
          rd_open = 1'b0;
          wr_cyc = cyc;
          quiet = 1'b1;
          wr_total++;
        end else begin
          rd_a = mem_cmd_addr;
          rd_open = 1'b1;
        end
      end
    end
    prev_req = req_valid;
  end

  // Random and corner requests, answers checked one cycle on
  task automatic remap_run(input int n);
    logic [36:0] e;
    logic        pv;
    logic [35:0] corner [6];
    corner = '{BASE - 36'h1, BASE, BASE + LRB - TOP - 36'h1, BASE + LRB - TOP, LIM, LIM + 36'h1};
    pv = 1'b0;
    e = '0;
    for (int i = 0; i <= n; i++) begin
      @(posedge sys_clk);
      #1;
      chk_flag(phys_valid, pv, "answer pulse");
      chk_flag(remapped, pv & e[36], "remap decision");
      if (pv) chk_val(phys_addr, e[35:0], "physical address");
      pv = (i < 6) || ((i < n) && ($urandom_range(2) != 0));
      req_addr = (i < 6) ? corner[i] : BASE - 36'h40 + 36'($urandom_range(1343));
      req_valid = pv;
      e = remap_exp(req_addr);
    end
    $display("test remap done");
  endtask : remap_run

  // One full pass of 16 scrubs with one line read back damaged
  task automatic scrub_pass(input int line, input logic [143:0] mask, input string name);
    int start;
    start = wr_total;
    // Arm the fault just after a write, so no read of that line is in flight
    for (int i = 0; i < 400 && wr_total == start; i++) @(posedge sys_clk);
    #1;
    inj_addr = 36'(line) << 6;
    inj_mask = mask;
    start = wr_total;
    for (int i = 0; i < 3000 && wr_total < start + 16; i++) @(posedge sys_clk);
    #1;
    inj_mask = '0;
    chk_flag(wr_total >= start + 16, 1'b1, "scrub pass finished");
    for (int i = 0; i < 16; i++) chk_val(mem_u.mem[i], exp_w[i], "line after scrub");
    $display("test %s done", name);
  endtask : scrub_pass

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    {sys_clk, reset_n, req_valid, prev_req} = '0;
    {req_addr, inj_mask, err_count, samples_checked, cyc, fix_cnt, fat_cnt, wr_total} = '0;
    inj_addr = '1;
    seed_v = $urandom(32'h0000_136f);
    repeat (10) @(posedge sys_clk);
    #1;
    chk_flag(init_busy, 1'b1, "init pending in reset");
    chk_flag(mem_cmd_valid, 1'b0, "port idle in reset");
    repeat (10) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 400 && init_busy !== 1'b0; i++) @(posedge sys_clk);
    #1;
    chk_flag(init_busy, 1'b0, "init finished");
    for (int i = 0; i < 16; i++) chk_val(mem_u.mem[i], '0, "line after init");
    $display("test init done");
    for (int i = 0; i < 16; i++) begin
      exp_w[i] = enc({$urandom, $urandom, $urandom, $urandom});
      mem_u.mem[i] = exp_w[i];
    end
    fork
      remap_run(200);
      scrub_pass(3, 144'h0001 << 77, "single bit");
    join
    scrub_pass(5, 144'h000f << 56, "nibble");
    // Unequal faults in two bytes, so both syndromes are nonzero and match no byte
    exp_w[9] = exp_w[9] ^ 144'h0201;
    scrub_pass(9, 144'h0201, "two bytes");
    chk_flag(fix_cnt == 2 && fat_cnt == 1, 1'b1, "error pulses");
    test_done();
  end
endmodule : tb
